// >>> hw/flash_lock_pkg.sv
// Operation
// - After a suspend the controller writes read-status and checks the suspended bit.
// - While suspended the controller holds write-protect unchanged and reset/power-down high, unless power-down is written in the cycle the suspend poll completes.
// - Set lock-bit is a setup write then a confirm write at the target address.
// - After set lock-bit the controller checks program fault and clears status on error.
// - After clear lock-bits the controller checks erase fault and clears status on error.
// - A clear aborted by power-down leaves lock bits unknown; repeat the clear.
package flash_lock_pkg;
	localparam int CLK_NS        = 25;
	localparam int T_SETUP_NS    = 25;
	localparam int T_STROBE_NS   = 75;
	localparam int T_HOLD_NS     = 25;
	localparam int T_POLL_NS     = 1000;
	localparam int T_RES_GAP_NS  = 20000;

	// Least times, so round up and never below one cycle.
	function automatic int cycles_up(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction : cycles_up

	localparam int SETUP_CYC     = cycles_up(T_SETUP_NS);
	localparam int STROBE_CYC    = cycles_up(T_STROBE_NS);
	localparam int HOLD_CYC      = cycles_up(T_HOLD_NS);
	localparam int POLL_CYC      = cycles_up(T_POLL_NS);
	localparam int RES_GAP_CYC   = cycles_up(T_RES_GAP_NS);

	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_CFG    = 8'h04;
	localparam logic [7:0] REG_ADDR   = 8'h08;
	localparam logic [7:0] REG_DATA   = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_RDATA  = 8'h14;

	localparam int CFG_POWERDOWN     = 0;
	localparam int CFG_WP_HIGH       = 1;
	localparam int STAT_BUSY         = 8;
	localparam int STAT_SUSPENDED    = 9;
	localparam int STAT_FAULT        = 10;
	localparam int STAT_REFUSED      = 11;
	localparam int STAT_LOCK_UNKNOWN = 12;
	localparam int STAT_RDY_PIN      = 13;

	localparam int SR_READY          = 7;
	localparam int SR_ERASE_FAULT    = 5;
	localparam int SR_PROG_FAULT     = 4;
	localparam int SR_SUPPLY_LOW     = 3;
	localparam int SR_SUSPENDED      = 2;
	localparam int SR_LOCK_VIOL      = 1;
	localparam logic [7:0] SR_FAULT_MASK = 8'h3A;

	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_WORD_WRITE  = 8'h40;

	typedef enum logic [3:0] {
		OP_PROGRAM,
		OP_SUSPEND,
		OP_RESUME,
		OP_SET_BLOCK_LOCK,
		OP_SET_PERM_LOCK,
		OP_CLEAR_LOCKS,
		OP_READ_ARRAY,
		OP_READ_STATUS,
		OP_CLEAR_STATUS
	} op_type;
endpackage : flash_lock_pkg

// >>> hw/poll_divider.sv
module poll_divider
	import flash_lock_pkg::*;
#(
	parameter int PERIOD = POLL_CYC
) (
	input  wire logic mclk,
	input  wire logic resetn,
	input  wire logic run,
	output logic      tick
);
	localparam int CW = $clog2(PERIOD + 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          tick;
	} div_type;

	div_type cur;
	div_type nx;

	always_comb begin
		nx = cur;
		nx.tick = 1'b0;
		if (!run) begin
			nx.cnt = '0;
		end else if (cur.cnt == CW'(PERIOD - 1)) begin
			nx.cnt = '0;
			nx.tick = 1'b1;
		end else begin
			nx.cnt = cur.cnt + 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			cur <= '0;
		end else begin
			cur <= nx;
		end
	end

	assign tick = cur.tick;
endmodule : poll_divider

// >>> hw/flash_bus_cycle.sv
module flash_bus_cycle
	import flash_lock_pkg::*;
#(
	parameter int AW = 21,
	parameter int DW = 16
) (
	input  wire logic          mclk,
	input  wire logic          resetn,
	input  wire logic          start,
	input  wire logic          write,
	input  wire logic          abort,
	input  wire logic [AW-1:0] addr,
	input  wire logic [DW-1:0] wdata,
	input  wire logic [DW-1:0] dq_in,
	output logic               done,
	output logic [DW-1:0]      rdata,
	output logic [AW-1:0]      flash_addr,
	output logic [DW-1:0]      dq_out,
	output logic               dq_oe,
	output logic               ce_n,
	output logic               oe_n,
	output logic               we_n
);
	localparam int CW = 4;

	typedef enum logic [1:0] {P_IDLE, P_SETUP, P_STROBE, P_HOLD} phase_type;

	typedef struct packed {
		phase_type     phase;
		logic [CW-1:0] cnt;
		logic          write;
		logic          done;
		logic [DW-1:0] rdata;
		logic [AW-1:0] flash_addr;
		logic [DW-1:0] dq_out;
		logic          dq_oe;
		logic          ce_n;
		logic          oe_n;
		logic          we_n;
	} cyc_type;

	cyc_type cur;
	cyc_type nx;

	always_comb begin
		nx = cur;
		nx.done = 1'b0;
		unique case (cur.phase)
			P_IDLE: begin
				if (start) begin
					nx.phase = P_SETUP;
					nx.cnt = CW'(SETUP_CYC - 1);
					nx.write = write;
					nx.flash_addr = addr;
					nx.dq_out = wdata;
					nx.dq_oe = write;
					nx.ce_n = 1'b0;
				end
			end
			P_SETUP: begin
				if (cur.cnt == '0) begin
					nx.phase = P_STROBE;
					nx.cnt = CW'(STROBE_CYC - 1);
					nx.we_n = !cur.write;
					nx.oe_n = cur.write;
				end else begin
					nx.cnt = cur.cnt - 1'b1;
				end
			end
			P_STROBE: begin
				if (cur.cnt == '0) begin
					// Data are latched by the device on the rising write strobe.
					if (!cur.write) begin
						nx.rdata = dq_in;
					end
					nx.phase = P_HOLD;
					nx.cnt = CW'(HOLD_CYC - 1);
					nx.we_n = 1'b1;
					nx.oe_n = 1'b1;
				end else begin
					nx.cnt = cur.cnt - 1'b1;
				end
			end
			P_HOLD: begin
				if (cur.cnt == '0) begin
					nx.phase = P_IDLE;
					nx.ce_n = 1'b1;
					nx.dq_oe = 1'b0;
					nx.done = 1'b1;
				end else begin
					nx.cnt = cur.cnt - 1'b1;
				end
			end
		endcase
		// Power-down cuts a cycle short; the pins return to idle at once.
		if (abort) begin
			nx.phase = P_IDLE;
			nx.done = 1'b0;
			nx.ce_n = 1'b1;
			nx.oe_n = 1'b1;
			nx.we_n = 1'b1;
			nx.dq_oe = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			cur <= '0;
			cur.ce_n <= 1'b1;
			cur.oe_n <= 1'b1;
			cur.we_n <= 1'b1;
		end else begin
			cur <= nx;
		end
	end

	assign done = cur.done;
	assign rdata = cur.rdata;
	assign flash_addr = cur.flash_addr;
	assign dq_out = cur.dq_out;
	assign dq_oe = cur.dq_oe;
	assign ce_n = cur.ce_n;
	assign oe_n = cur.oe_n;
	assign we_n = cur.we_n;

	no_contend_a: assert property (@(posedge mclk) disable iff (!resetn) dq_oe |-> oe_n)
		else $error("Data driven while the device output is enabled.");
	we_width_a: assert property (@(posedge mclk) disable iff (!resetn) $fell(we_n) |-> (!we_n && !ce_n) [*3])
		else $error("Write strobe shorter than its least width.");
endmodule : flash_bus_cycle

// >>> hw/flash_write_suspend_lock_ctrl.sv
module flash_write_suspend_lock_ctrl
	import flash_lock_pkg::*;
#(
	parameter int         AW                = 21,
	parameter int         DW                = 16,
	parameter int         GAP_CYC           = RES_GAP_CYC,
	parameter int         POLL_PERIOD       = POLL_CYC,
	parameter logic [7:0] SUSPEND_CODE      = 8'hB0,
	parameter logic [7:0] RESUME_CODE       = 8'hD0,
	parameter logic [7:0] LOCK_SETUP_CODE   = 8'h60,
	parameter logic [7:0] BLOCK_CONFIRM     = 8'h01,
	parameter logic [7:0] PERM_CONFIRM      = 8'hF1,
	parameter logic [7:0] CLEAR_SETUP_CODE  = 8'h60,
	parameter logic [7:0] CLEAR_CONFIRM     = 8'hD0,
	parameter logic [7:0] READ_ARRAY_CODE   = 8'hFF,
	parameter logic [7:0] CLEAR_STATUS_CODE = 8'h50
) (
	input  wire logic          mclk,
	input  wire logic          resetn,
	input  wire logic [7:0]    addr,
	input  wire logic [31:0]   wdata,
	input  wire logic          wr,
	input  wire logic          rd,
	output logic [31:0]        rdata,
	output logic [AW-1:0]      flash_addr,
	output logic [DW-1:0]      dq_out,
	output logic               dq_oe,
	input  wire logic [DW-1:0] dq_in,
	output logic               ce_n,
	output logic               oe_n,
	output logic               we_n,
	output logic               reset_powerdown_n,
	output logic               write_protect_n,
	input  wire logic          ready_busy_n
);
	localparam int GW = $clog2(GAP_CYC + 1);

	typedef enum logic [2:0] {ST_IDLE, ST_CMD1, ST_CMD2, ST_WAIT, ST_POLL, ST_CLEAR, ST_READ} step_type;

	typedef struct packed {
		step_type      step;
		op_type        op;
		logic          issued;
		logic [AW-1:0] addr;
		logic [DW-1:0] data;
		logic [7:0]    sr;
		logic [DW-1:0] rd_word;
		logic [31:0]   rdata;
		logic          suspended;
		logic [AW-1:0] susp_addr;
		logic          fault;
		logic          refused;
		logic          lock_unknown;
		logic          rbn;
		logic          rp_n;
		logic          wp_n;
		logic [GW-1:0] gap;
		logic          cyc_start;
		logic          cyc_write;
		logic          cyc_abort;
		logic [AW-1:0] cyc_addr;
		logic [DW-1:0] cyc_wdata;
	} state_type;

	state_type     cur;
	state_type     nx;
	logic          tick;
	logic          cyc_done;
	logic [DW-1:0] cyc_rdata;
	op_type        req_op;
	logic          req_legal;
	logic          susp_ok;
	logic          take_idle;
	logic          take_suspend;
	logic          accept;

	function automatic logic [DW-1:0] cmd_word(input logic [7:0] code);
		return {{(DW-8){1'b0}}, code};
	endfunction : cmd_word

	function automatic logic [DW-1:0] step_word(input step_type s, input op_type o, input logic [DW-1:0] d);
		logic [7:0] c;
		c = CMD_READ_STATUS;
		if (s == ST_CLEAR) begin
			c = CLEAR_STATUS_CODE;
		end else if (s == ST_CMD1) begin
			unique case (o)
				OP_PROGRAM:                         c = CMD_WORD_WRITE;
				OP_SUSPEND:                         c = SUSPEND_CODE;
				OP_RESUME:                          c = RESUME_CODE;
				OP_SET_BLOCK_LOCK, OP_SET_PERM_LOCK: c = LOCK_SETUP_CODE;
				OP_CLEAR_LOCKS:                     c = CLEAR_SETUP_CODE;
				OP_READ_ARRAY:                      c = READ_ARRAY_CODE;
				OP_READ_STATUS:                     c = CMD_READ_STATUS;
				OP_CLEAR_STATUS:                    c = CLEAR_STATUS_CODE;
			endcase
		end else if (s == ST_CMD2) begin
			if (o == OP_PROGRAM) begin
				return d;
			end else if (o == OP_SET_BLOCK_LOCK) begin
				c = BLOCK_CONFIRM;
			end else if (o == OP_SET_PERM_LOCK) begin
				c = PERM_CONFIRM;
			end else if (o == OP_CLEAR_LOCKS) begin
				c = CLEAR_CONFIRM;
			end
		end
		return cmd_word(c);
	endfunction : step_word

	// --------------------------------------------------------------
	// Command acceptance
	// --------------------------------------------------------------
	assign req_op = op_type'(wdata[3:0]);
	assign req_legal = wdata[3:0] <= OP_CLEAR_STATUS;
	assign susp_ok = (req_op == OP_READ_STATUS) || (req_op == OP_RESUME) ||
		((req_op == OP_READ_ARRAY) && (cur.addr != cur.susp_addr));
	assign take_idle = (cur.step == ST_IDLE) && cur.rp_n && (req_op != OP_SUSPEND) &&
		(cur.suspended ? susp_ok : (req_op != OP_RESUME));
	assign take_suspend = (req_op == OP_SUSPEND) && (cur.step == ST_WAIT) && !cur.suspended &&
		((cur.op == OP_PROGRAM) || (cur.op == OP_RESUME)) && (cur.gap == '0);
	assign accept = req_legal && (take_idle || take_suspend);

	// --------------------------------------------------------------
	// Sequencer and register port
	// --------------------------------------------------------------
	always_comb begin
		nx = cur;
		nx.cyc_start = 1'b0;
		nx.cyc_abort = 1'b0;
		nx.rdata = '0;
		nx.rbn = ready_busy_n;
		if (cur.gap != '0) begin
			nx.gap = cur.gap - 1'b1;
		end
		// Clears come first so that a flag raised in the same cycle survives.
		if (wr && (addr == REG_STATUS)) begin
			if (wdata[STAT_FAULT]) begin
				nx.fault = 1'b0;
			end
			if (wdata[STAT_REFUSED]) begin
				nx.refused = 1'b0;
			end
		end
		unique case (cur.step)
			ST_IDLE: begin
			end
			ST_WAIT: begin
				if (tick) begin
					nx.step = ST_POLL;
				end
			end
			ST_CMD1, ST_CMD2, ST_POLL, ST_CLEAR, ST_READ: begin
				if (!cur.issued) begin
					nx.issued = 1'b1;
					nx.cyc_start = 1'b1;
					nx.cyc_write = (cur.step != ST_POLL) && (cur.step != ST_READ);
					nx.cyc_addr = cur.addr;
					nx.cyc_wdata = step_word(cur.step, cur.op, cur.data);
				end else if (cyc_done) begin
					nx.issued = 1'b0;
					if (cur.step == ST_CMD1) begin
						if (cur.op == OP_RESUME) begin
							nx.step = ST_WAIT;
							nx.suspended = 1'b0;
							nx.gap = GW'(GAP_CYC);
						end else if ((cur.op == OP_READ_ARRAY) || (cur.op == OP_READ_STATUS)) begin
							nx.step = ST_READ;
						end else if (cur.op == OP_CLEAR_STATUS) begin
							nx.step = ST_IDLE;
						end else begin
							nx.step = ST_CMD2;
						end
					end else if (cur.step == ST_CMD2) begin
						nx.step = ST_WAIT;
					end else if (cur.step == ST_POLL) begin
						nx.sr = cyc_rdata[7:0];
						if (!cyc_rdata[SR_READY]) begin
							nx.step = ST_WAIT;
						end else begin
							if (cur.op == OP_SUSPEND) begin
								nx.suspended = cyc_rdata[SR_SUSPENDED];
							end
							if ((cyc_rdata[7:0] & SR_FAULT_MASK) != 8'h00) begin
								nx.fault = 1'b1;
								nx.step = ST_CLEAR;
							end else begin
								nx.step = ST_IDLE;
								if (cur.op == OP_CLEAR_LOCKS) begin
									nx.lock_unknown = 1'b0;
								end
							end
						end
					end else if (cur.step == ST_CLEAR) begin
						nx.step = ST_IDLE;
					end else begin
						nx.rd_word = cyc_rdata;
						if (cur.op == OP_READ_STATUS) begin
							nx.sr = cyc_rdata[7:0];
						end
						nx.step = ST_IDLE;
					end
				end
			end
		endcase
		if (wr) begin
			case (addr)
				REG_CTRL: begin
					if (accept) begin
						nx.op = req_op;
						nx.step = ST_CMD1;
						nx.issued = 1'b0;
						if (take_suspend) begin
							nx.susp_addr = cur.addr;
						end
					end else begin
						nx.refused = 1'b1;
					end
				end
				REG_CFG: begin
					if (cur.suspended || ((cur.step != ST_IDLE) && (wdata[CFG_WP_HIGH] != cur.wp_n))) begin
						nx.refused = 1'b1;
					end else begin
						nx.wp_n = wdata[CFG_WP_HIGH];
						nx.rp_n = !wdata[CFG_POWERDOWN];
						if (wdata[CFG_POWERDOWN] && (cur.step != ST_IDLE)) begin
							nx.step = ST_IDLE;
							nx.issued = 1'b0;
							nx.cyc_start = 1'b0;
							nx.cyc_abort = 1'b1;
							if (cur.op == OP_CLEAR_LOCKS) begin
								nx.lock_unknown = 1'b1;
							end
						end
					end
				end
				REG_ADDR, REG_DATA: begin
					if (cur.step != ST_IDLE) begin
						nx.refused = 1'b1;
					end else if (addr == REG_ADDR) begin
						nx.addr = wdata[AW-1:0];
					end else begin
						nx.data = wdata[DW-1:0];
					end
				end
				default: begin
				end
			endcase
		end
		if (rd) begin
			case (addr)
				REG_CTRL:   nx.rdata = 32'(cur.op);
				REG_CFG: begin
					nx.rdata[CFG_WP_HIGH] = cur.wp_n;
					nx.rdata[CFG_POWERDOWN] = !cur.rp_n;
				end
				REG_ADDR:   nx.rdata = 32'(cur.addr);
				REG_DATA:   nx.rdata = 32'(cur.data);
				REG_RDATA:  nx.rdata = 32'(cur.rd_word);
				REG_STATUS: begin
					nx.rdata[7:0] = cur.sr;
					nx.rdata[STAT_BUSY] = cur.step != ST_IDLE;
					nx.rdata[STAT_SUSPENDED] = cur.suspended;
					nx.rdata[STAT_FAULT] = cur.fault;
					nx.rdata[STAT_REFUSED] = cur.refused;
					nx.rdata[STAT_LOCK_UNKNOWN] = cur.lock_unknown;
					nx.rdata[STAT_RDY_PIN] = cur.rbn;
				end
				default:    nx.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			cur <= '0;
			cur.rp_n <= 1'b1;
			cur.rbn <= 1'b1;
		end else begin
			cur <= nx;
		end
	end

	assign rdata = cur.rdata;
	assign reset_powerdown_n = cur.rp_n;
	assign write_protect_n = cur.wp_n;

	poll_divider #(.PERIOD(POLL_PERIOD)) u_poll (
		.mclk   (mclk),
		.resetn (resetn),
		.run    (cur.step == ST_WAIT),
		.tick   (tick)
	);

	flash_bus_cycle #(.AW(AW), .DW(DW)) u_cycle (
		.mclk       (mclk),
		.resetn     (resetn),
		.start      (cur.cyc_start),
		.write      (cur.cyc_write),
		.abort      (cur.cyc_abort),
		.addr       (cur.cyc_addr),
		.wdata      (cur.cyc_wdata),
		.dq_in      (dq_in),
		.done       (cyc_done),
		.rdata      (cyc_rdata),
		.flash_addr (flash_addr),
		.dq_out     (dq_out),
		.dq_oe      (dq_oe),
		.ce_n       (ce_n),
		.oe_n       (oe_n),
		.we_n       (we_n)
	);

	susp_status_a: assert property (@(posedge mclk) disable iff (!resetn)
		(cyc_done && cur.issued && cur.step == ST_CMD1 && cur.op == OP_SUSPEND) |->
		##[1:3] (cur.cyc_start && cur.cyc_write && cur.cyc_wdata == cmd_word(CMD_READ_STATUS)))
		else $error("No read-status write after a suspend.");
	rp_held_a: assert property (@(posedge mclk) disable iff (!resetn) cur.suspended |-> cur.rp_n)
		else $error("Power-down asserted while suspended.");
	wp_stable_a: assert property (@(posedge mclk) disable iff (!resetn)
		(cur.suspended && $past(cur.suspended)) |-> $stable(cur.wp_n))
		else $error("Write-protect changed while suspended.");
	lock_setup_a: assert property (@(posedge mclk) disable iff (!resetn)
		(cur.cyc_start && cur.step == ST_CMD1 && (cur.op == OP_SET_BLOCK_LOCK || cur.op == OP_SET_PERM_LOCK))
		|-> cur.cyc_write && cur.cyc_wdata == cmd_word(LOCK_SETUP_CODE))
		else $error("Lock setup write carries the wrong code.");
	block_confirm_a: assert property (@(posedge mclk) disable iff (!resetn)
		(cur.cyc_start && cur.step == ST_CMD2 && cur.op == OP_SET_BLOCK_LOCK)
		|-> cur.cyc_wdata == cmd_word(BLOCK_CONFIRM) && cur.cyc_addr == cur.addr)
		else $error("Block lock confirm has the wrong code or address.");
	prog_fault_a: assert property (@(posedge mclk) disable iff (!resetn)
		(cyc_done && cur.issued && cur.step == ST_POLL && cur.op == OP_SET_BLOCK_LOCK &&
		cyc_rdata[SR_READY] && cyc_rdata[SR_PROG_FAULT] && !(wr && addr == REG_CFG))
		|-> ##[1:3] (cur.cyc_start && cur.cyc_wdata == cmd_word(CLEAR_STATUS_CODE)))
		else $error("Program fault not followed by a status clear.");
	erase_fault_a: assert property (@(posedge mclk) disable iff (!resetn)
		(cyc_done && cur.issued && cur.step == ST_POLL && cur.op == OP_CLEAR_LOCKS &&
		cyc_rdata[SR_READY] && cyc_rdata[SR_ERASE_FAULT] && !(wr && addr == REG_CFG))
		|-> ##[1:3] (cur.cyc_start && cur.cyc_wdata == cmd_word(CLEAR_STATUS_CODE)))
		else $error("Erase fault not followed by a status clear.");
	abort_unknown_a: assert property (@(posedge mclk) disable iff (!resetn)
		(wr && addr == REG_CFG && wdata[CFG_POWERDOWN] && wdata[CFG_WP_HIGH] == cur.wp_n &&
		cur.step != ST_IDLE && cur.op == OP_CLEAR_LOCKS && !cur.suspended)
		|=> (cur.lock_unknown && !reset_powerdown_n) ##1 ce_n)
		else $error("Aborted clear did not mark lock bits unknown.");
endmodule : flash_write_suspend_lock_ctrl

// >>> dv/flash_model.sv
// ----------------------------------------------------------------
// Behavioural flash device seen from its pins
// ----------------------------------------------------------------
module flash_model (
	input  wire logic [20:0] flash_addr,
	input  wire logic        mclk,
	input  wire logic [15:0] dq_out,
	output logic      [15:0] dq_in,
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic        reset_powerdown_n,
	output logic             ready_busy_n
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam bit SUPPLY_LOW = 1'b0;
	logic [7:0]  st = 8'h80;
	logic [7:0]  pend = 8'h00;
	logic [15:0] last = 16'h0000;
	logic [15:0] val;
	logic [31:0] blk = 32'h0000_0000;
	logic        perm = 1'b0;
	logic        susp = 1'b0;
	logic        arr = 1'b1;
	logic        wip = 1'b0;
	logic        we_q = 1'b1;
	int          busy = 0;
	int          saved = 0;
	// reads give status unless read array was ordered, or after power-up or power-down.
	assign val = arr ? (flash_addr[15:0] ^ 16'h5A5A) : {8'h00, st};
	// A released bus shows the inverse of its last value, so a late sample cannot pass by luck.
	assign dq_in = (!ce_n && !oe_n) ? val : ~last;
	// ready/busy pulls low only while the algorithm runs.
	assign ready_busy_n = (busy > 0) ? 1'b0 : 1'b1;

	task automatic cmd(input logic [7:0] c);
		arr = 1'b0;
		if (pend == 8'h40) begin
			// a locked block refuses the write.
			busy = blk[flash_addr[20:16]] ? 5 : 120;
			st = blk[flash_addr[20:16]] ? 8'h12 : 8'h00;
			wip = !blk[flash_addr[20:16]];
			pend = 8'h00;
		end else if (pend == 8'h60) begin
			busy = 30;
			pend = 8'h00;
			case (c)
				8'h01: begin
					st = perm ? 8'h12 : 8'h00;
					if (!perm) blk[flash_addr[20:16]] = 1'b1;
				end
				8'hF1: begin
					perm = 1'b1;
					st = 8'h00;
				end
				8'hD0: begin
					st = SUPPLY_LOW ? 8'h28 : (perm ? 8'h22 : 8'h00);
					if (!perm && !SUPPLY_LOW) blk = 32'h0000_0000;
				end
				default: st = 8'h30;
			endcase
		end else if (!susp || c inside {8'h70, 8'hFF, 8'hD0}) begin
			// while suspended other codes are ignored.
			case (c)
				8'h40, 8'h60: pend = c;
				// suspend a running write, or fall back to read array.
				8'hB0: begin
					if (wip && busy > 0) begin
						saved = busy;
						busy = 0;
						susp = 1'b1;
						st = 8'h84;
					end else arr = 1'b1;
				end
				// resume clears the ready and suspended bits.
				8'hD0: begin
					if (susp) begin
						busy = saved;
						susp = 1'b0;
						st = 8'h00;
					end
				end
				8'hFF: arr = 1'b1;
				8'h50: st = st & ~8'h3A;
				default: ;
			endcase
		end
	endtask : cmd

	always @(posedge mclk) begin
		we_q <= we_n;
		if (!ce_n && !oe_n) last <= val;
		if (!reset_powerdown_n) begin
			// an aborted clear leaves the lock bits scrambled.
			if (busy > 0 && !wip) blk = ~blk;
			busy = 0;
			st = 8'h80;
			arr = 1'b1;
			susp = 1'b0;
			pend = 8'h00;
			wip = 1'b0;
		end else begin
			if (busy == 1) begin
				st[7] = 1'b1;
				wip = 1'b0;
			end
			if (busy > 0) busy = busy - 1;
			if (we_n && !we_q && !ce_n) cmd(dq_out[7:0]);
		end
	end
endmodule : flash_model

// >>> dv/tb_top.sv
module tb_top
	import flash_lock_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        mclk = 1'b0;
	logic        resetn = 1'b0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] rdata;
	logic [31:0] d;
	logic [20:0] flash_addr;
	logic [15:0] dq_out;
	logic [15:0] dq_in;
	logic        dq_oe;
	logic        ce_n;
	logic        oe_n;
	logic        we_n;
	logic        rp_n;
	logic        wp_n;
	logic        rb_n;
	int          err_total = 0;
	int          n_tests = 0;
	logic [3:0]  ops [4] = '{4'h0, 4'h4, 4'h3, 4'h5};
	logic [31:0] exs [4] = '{32'h0000_0492, 32'h0000_0080, 32'h0000_0492, 32'h0000_04A2};

	always #12.5 mclk = ~mclk;

	flash_write_suspend_lock_ctrl #(.GAP_CYC(4), .POLL_PERIOD(2)) flash_write_suspend_lock_ctrl_inst (
		.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.flash_addr(flash_addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .ce_n(ce_n),
		.oe_n(oe_n), .we_n(we_n), .reset_powerdown_n(rp_n), .write_protect_n(wp_n), .ready_busy_n(rb_n));
	flash_model flash_model_inst (
		.flash_addr(flash_addr), .mclk(mclk), .dq_out(dq_out), .dq_in(dq_in), .ce_n(ce_n),
		.oe_n(oe_n), .we_n(we_n), .reset_powerdown_n(rp_n), .ready_busy_n(rb_n));

	task automatic final_report();
		$display("errors %0d of %0d checks", err_total, n_tests);
		if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : final_report

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		@(posedge mclk);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		@(negedge mclk);
		v = rdata;
	endtask : rd_reg

	// The status word read last stays in d for the caller.
	// A refused order is retried, because a suspend is only taken while the sequencer waits for its next status poll.
	task automatic op(input logic [3:0] code);
		int i;
		int j;
		for (j = 0; j < 12; j++) begin
			wr_reg(REG_CTRL, {28'h000_0000, code});
			rd_reg(REG_STATUS, d);
			if (d[STAT_REFUSED] === 1'b0) break;
			wr_reg(REG_STATUS, 32'h0000_0800);
		end
		for (i = 0; i < 3000; i++) begin
			rd_reg(REG_STATUS, d);
			if (d[STAT_BUSY] === 1'b0) break;
		end
		if (i == 3000 || j == 12) begin
			err_total++;
			final_report();
		end
	endtask : op

	initial begin
		repeat (20) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		check({30'h0, rp_n, wp_n}, 32'h0000_0002);
		check({28'h0, dq_oe, ce_n, oe_n, we_n}, 32'h0000_0007);
		rd_reg(8'h20, d);
		check(d, 32'h0000_0000);
		wr_reg(REG_CFG, 32'h0000_0002);
		wr_reg(REG_ADDR, 32'h0001_2340);
		wr_reg(REG_DATA, 32'h0000_BEEF);
		wr_reg(REG_CTRL, 32'h0000_0000);
		repeat (40) @(posedge mclk);
		op(4'h1);
		check(d & 32'h0000_02FF, 32'h0000_0284);
		check({31'h0, rb_n}, 32'h0000_0001);
		wr_reg(REG_CTRL, 32'h0000_0003);
		rd_reg(REG_STATUS, d);
		check(d & 32'h0000_0B00, 32'h0000_0A00);
		wr_reg(REG_STATUS, 32'h0000_0800);
		wr_reg(REG_CFG, 32'h0000_0000);
		rd_reg(REG_STATUS, d);
		check({d[STAT_REFUSED], wp_n}, 32'h0000_0003);
		wr_reg(REG_STATUS, 32'h0000_0800);
		op(4'h2);
		check(d & 32'h0000_06FF, 32'h0000_0080);
		wr_reg(REG_ADDR, 32'h0003_0000);
		op(4'h3);
		check(d & 32'h0000_04FF, 32'h0000_0080);
		for (int k = 0; k < 4; k++) begin
			wr_reg(REG_STATUS, 32'h0000_0400);
			op(ops[k]);
			check(d & 32'h0000_04FF, exs[k]);
		end
		wr_reg(REG_ADDR, 32'h0000_0100);
		op(4'h6);
		rd_reg(REG_RDATA, d);
		check(d, 32'h0000_5B5A);
		wr_reg(REG_CTRL, 32'h0000_0005);
		wr_reg(REG_CFG, 32'h0000_0003);
		@(posedge mclk);
		check({31'h0, rp_n}, 32'h0000_0000);
		rd_reg(REG_STATUS, d);
		check(d & 32'h0000_1100, 32'h0000_1000);
		wr_reg(REG_CFG, 32'h0000_0002);
		final_report();
	end
endmodule : tb_top
